// File: core/mmu_pkg.sv
// Constants and types shared by the address extender and its stack pointer unit.
package mmu_pkg;
  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int REG_ADDR_W = 8;
  localparam int DATA_W     = 8;
  localparam int LOG_W      = 16;
  localparam int PHYS_W     = 22;
  localparam int SEG_W      = 6;
  localparam int PAGE_W     = 8;
  localparam int OFFS_W     = 14;
  localparam int PPTR_W     = 6;
  localparam int NUM_DPR    = 4;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] MODE_CTRL_ADDR  = 8'hEB;
  localparam logic [7:0] EXT_MODE2_ADDR  = 8'hF6;
  localparam logic [5:0] MMU_PAGE        = 6'h15;
  localparam logic [7:0] DPR_BASE_F      = 8'hF0;
  localparam logic [7:0] DPR_BASE_E      = 8'hE0;
  localparam logic [7:0] CODE_SEG_ADDR   = 8'hF8;
  localparam logic [7:0] IRQ_SEG_ADDR    = 8'hF9;
  localparam logic [7:0] DMA_SEG_ADDR    = 8'hFA;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int EXT2_DPR_REMAP_BIT = 5;
  localparam int EXT2_CS_ENABLE_BIT = 7;
  localparam int MODE_SYS_STACK_BIT = 1;
  localparam int MODE_USR_STACK_BIT = 0;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [5:0]  SEG_RESET  = 6'h00;
  localparam logic [15:0] SP_RESET   = 16'h0000;
  localparam logic [15:0] SP_STEP    = 16'h0001;

  // Kind of memory access, one-hot.
  typedef enum logic [3:0] {
    ACC_PROG = 4'h1,
    ACC_DATA = 4'h2,
    ACC_DMA  = 4'h4,
    ACC_IRQ  = 4'h8
  } acc_kind_t;
endpackage

// File: core/stack_if.sv
// Signals between the address extender and its stack pointer unit.
`timescale 1ns/100ps
interface stack_if;
  logic        sys_push;
  logic        sys_pop;
  logic        usr_push;
  logic        usr_pop;
  logic        load_sys;
  logic        load_usr;
  logic [15:0] load_value;
  logic        sys_in_regfile;
  logic        usr_in_regfile;
  logic [15:0] stack_addr;
  logic        stack_regfile;
  logic        stack_valid;
  logic [15:0] sys_ptr;
  logic [15:0] usr_ptr;

  modport ctrl (output sys_push, sys_pop, usr_push, usr_pop, load_sys, load_usr,
                output load_value, sys_in_regfile, usr_in_regfile,
                input stack_addr, stack_regfile, stack_valid, sys_ptr, usr_ptr);
  modport unit (input sys_push, sys_pop, usr_push, usr_pop, load_sys, load_usr,
                input load_value, sys_in_regfile, usr_in_regfile,
                output stack_addr, stack_regfile, stack_valid, sys_ptr, usr_ptr);
endinterface

// File: core/stack_pointer_unit.sv
// System and user stack pointers with pre-decrement push and post-increment pop.
`timescale 1ns/100ps
module stack_pointer_unit (
  input wire logic clk,
  input wire logic rst,
  stack_if.unit    sp
);
  // ****************************************************************
  // Operation decode
  // ****************************************************************
  // A system push or pop takes the cycle; a user push or pop in the same cycle is dropped.
  wire        sys_op   = sp.sys_push | sp.sys_pop;
  wire        usr_op   = (sp.usr_push | sp.usr_pop) & ~sys_op;
  wire [15:0] sys_dec  = sp.sys_ptr - mmu_pkg::SP_STEP;
  wire [15:0] sys_inc  = sp.sys_ptr + mmu_pkg::SP_STEP;
  wire [15:0] usr_dec  = sp.usr_ptr - mmu_pkg::SP_STEP;
  wire [15:0] usr_inc  = sp.usr_ptr + mmu_pkg::SP_STEP;

  // System stack pointer: loads, pushes and pops by the core.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp.sys_ptr <= mmu_pkg::SP_RESET;
    end else if (sp.load_sys) begin
      sp.sys_ptr <= sp.load_value;
    end else if (sp.sys_push) begin
      sp.sys_ptr <= sys_dec;
    end else if (sp.sys_pop) begin
      sp.sys_ptr <= sys_inc;
    end
  end

  // User stack pointer moves only on explicit user operations.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp.usr_ptr <= mmu_pkg::SP_RESET;
    end else if (sp.load_usr) begin
      sp.usr_ptr <= sp.load_value;
    end else if (usr_op && sp.usr_push) begin
      sp.usr_ptr <= usr_dec;
    end else if (usr_op) begin
      sp.usr_ptr <= usr_inc;
    end
  end

  // Stack access address: push writes below the old pointer, pop reads at it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp.stack_addr    <= mmu_pkg::SP_RESET;
      sp.stack_regfile <= 1'b0;
      sp.stack_valid   <= 1'b0;
    end else begin
      sp.stack_valid   <= sys_op | usr_op;
      sp.stack_regfile <= sys_op ? sp.sys_in_regfile : sp.usr_in_regfile;
      if (sys_op) begin
        sp.stack_addr <= sp.sys_push ? sys_dec : sp.sys_ptr;
      end else if (usr_op) begin
        sp.stack_addr <= sp.usr_push ? usr_dec : sp.usr_ptr;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sys_push_seq;
    sp.sys_push && !sp.load_sys;
  endsequence
  sequence sys_pop_seq;
    sp.sys_pop && !sp.sys_push && !sp.load_sys;
  endsequence

  push_pre_dec_a: assert property (sys_push_seq |=> sp.stack_valid &&
      sp.stack_addr == $past(sp.sys_ptr) - mmu_pkg::SP_STEP && sp.sys_ptr == sp.stack_addr)
    else $error("push did not decrement before writing");
  pop_post_inc_a: assert property (sys_pop_seq |=> sp.stack_addr == $past(sp.sys_ptr) &&
      sp.sys_ptr == sp.stack_addr + mmu_pkg::SP_STEP)
    else $error("pop did not read before incrementing");
  usr_hold_a: assert property (!sp.usr_push && !sp.usr_pop && !sp.load_usr
      |=> $stable(sp.usr_ptr))
    else $error("user stack pointer moved without a user operation");
  stack_loc_a: assert property (sp.sys_push |=> sp.stack_regfile == $past(sp.sys_in_regfile))
    else $error("system stack location not honoured");
endmodule

// File: core/mmu_address_extender.sv
// Segment and page address extension from 16-bit logical to 22-bit physical addresses.
`timescale 1ns/100ps

// How it works
// - DMA with page-select set takes its segment from the DMA segment register.
// - DMA with page-select clear takes its segment from the interrupt segment register.
// - Logical address bits 15:14 pick one of four data page registers.
// - Selected 8-bit page sits above the low 14 address bits, making 22 bits.
// - Every access kind takes the same single cycle; translation adds none.
// - Data page registers live in the memory-management page of group F.
// - Mode bit 5 of extended mode two moves them into group E.
// - Calls push return address and flags, plus code segment when enabled.
// - User stack pointer changes only on user push, user pop and user load.
// - Two mode bits place each stack in RAM (0) or register file (1).
// - Push decrements the pointer first, then writes.
// - Registers and data bus are 8 bits; words are register or byte pairs.
// - Program, DMA and interrupt accesses put 6 segment bits above 16 bits.
// - Pop reads at the pointer, then increments it.
module mmu_address_extender #(
  parameter int NUM_DPR = mmu_pkg::NUM_DPR
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic [mmu_pkg::REG_ADDR_W-1:0] reg_addr,
  input  wire logic [mmu_pkg::PPTR_W-1:0]     page_ptr,
  input  wire logic [mmu_pkg::DATA_W-1:0]     reg_wdata,
  input  wire logic                          reg_we,
  input  wire logic                          reg_re,
  output      logic [mmu_pkg::DATA_W-1:0]     reg_rdata,
  input  wire logic                          acc_valid,
  input  wire mmu_pkg::acc_kind_t             acc_kind,
  input  wire logic [mmu_pkg::LOG_W-1:0]      acc_addr,
  input  wire logic                          dma_page_select,
  output      logic [mmu_pkg::PHYS_W-1:0]     phys_addr,
  output      logic                          phys_valid,
  input  wire logic                          call_event,
  output      logic                          push_code_segment,
  input  wire logic                          sys_push,
  input  wire logic                          sys_pop,
  input  wire logic                          usr_push,
  input  wire logic                          usr_pop,
  input  wire logic                          load_sys,
  input  wire logic                          load_usr,
  input  wire logic [mmu_pkg::LOG_W-1:0]      load_value,
  output      logic [mmu_pkg::LOG_W-1:0]      stack_addr,
  output      logic                          stack_regfile,
  output      logic                          stack_valid
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [mmu_pkg::DATA_W-1:0] core_mode_control;
  logic [mmu_pkg::DATA_W-1:0] extended_mode_control_two;
  logic [mmu_pkg::SEG_W-1:0]  code_segment_reg;
  logic [mmu_pkg::SEG_W-1:0]  interrupt_segment_reg;
  logic [mmu_pkg::SEG_W-1:0]  dma_segment_reg;
  logic [mmu_pkg::PAGE_W-1:0] data_page_reg [NUM_DPR];

  stack_if sp ();

  // Register decode for the fixed, paged and relocatable locations.
  wire dpr_remap   = extended_mode_control_two[mmu_pkg::EXT2_DPR_REMAP_BIT];
  wire in_mmu_page = (page_ptr == mmu_pkg::MMU_PAGE);
  wire hit_mode    = (reg_addr == mmu_pkg::MODE_CTRL_ADDR);
  wire hit_ext2    = in_mmu_page && (reg_addr == mmu_pkg::EXT_MODE2_ADDR);
  wire hit_code    = in_mmu_page && (reg_addr == mmu_pkg::CODE_SEG_ADDR);
  wire hit_irq     = in_mmu_page && (reg_addr == mmu_pkg::IRQ_SEG_ADDR);
  wire hit_dma     = in_mmu_page && (reg_addr == mmu_pkg::DMA_SEG_ADDR);
  wire hit_dpr_f   = !dpr_remap && in_mmu_page &&
                     (reg_addr[7:2] == mmu_pkg::DPR_BASE_F[7:2]);
  wire hit_dpr_e   = dpr_remap && (reg_addr[7:2] == mmu_pkg::DPR_BASE_E[7:2]);
  wire hit_dpr     = hit_dpr_f | hit_dpr_e;
  wire [1:0] dpr_idx = reg_addr[1:0];

  // Mode and segment registers, all cleared at reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_mode_control         <= mmu_pkg::REG_RESET;
      extended_mode_control_two <= mmu_pkg::REG_RESET;
      code_segment_reg          <= mmu_pkg::SEG_RESET;
      interrupt_segment_reg     <= mmu_pkg::SEG_RESET;
      dma_segment_reg           <= mmu_pkg::SEG_RESET;
    end else if (reg_we) begin
      if (hit_mode) core_mode_control <= reg_wdata;
      if (hit_ext2) extended_mode_control_two <= reg_wdata;
      if (hit_code) code_segment_reg <= reg_wdata[mmu_pkg::SEG_W-1:0];
      if (hit_irq) interrupt_segment_reg <= reg_wdata[mmu_pkg::SEG_W-1:0];
      if (hit_dma) dma_segment_reg <= reg_wdata[mmu_pkg::SEG_W-1:0];
    end
  end

  // One data page register per entry, written at its decoded location.
  for (genvar i = 0; i < NUM_DPR; i++) begin : g_dpr
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        data_page_reg[i] <= mmu_pkg::REG_RESET;
      end else if (reg_we && hit_dpr && dpr_idx == 2'(i)) begin
        data_page_reg[i] <= reg_wdata;
      end
    end
  end

  // Read mux; unmapped locations read zero.
  wire [7:0] seg_rd = hit_code ? {2'h0, code_segment_reg} :
                      hit_irq  ? {2'h0, interrupt_segment_reg} :
                      hit_dma  ? {2'h0, dma_segment_reg} : mmu_pkg::REG_RESET;
  wire [7:0] next_rdata = hit_mode ? core_mode_control :
                          hit_ext2 ? extended_mode_control_two :
                          hit_dpr  ? data_page_reg[dpr_idx] : seg_rd;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= mmu_pkg::REG_RESET;
    end else if (reg_re) begin
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // Address translation
  // ****************************************************************
  // Segment source by kind; DMA picks between its own and the interrupt segment.
  wire [5:0] dma_seg = dma_page_select ? dma_segment_reg : interrupt_segment_reg;
  wire [5:0] seg_sel = (acc_kind == mmu_pkg::ACC_DMA) ? dma_seg :
                       (acc_kind == mmu_pkg::ACC_IRQ) ? interrupt_segment_reg :
                       code_segment_reg;
  wire [1:0]  page_idx   = acc_addr[mmu_pkg::LOG_W-1:mmu_pkg::OFFS_W];
  wire [21:0] seg_phys   = {seg_sel, acc_addr};
  wire [21:0] data_phys  = {data_page_reg[page_idx], acc_addr[mmu_pkg::OFFS_W-1:0]};
  wire        is_data    = (acc_kind == mmu_pkg::ACC_DATA);
  wire [21:0] next_phys  = is_data ? data_phys : seg_phys;

  // Every kind of access is registered once, so all take the same time.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phys_addr  <= {mmu_pkg::PHYS_W{1'b0}};
      phys_valid <= 1'b0;
    end else begin
      phys_valid <= acc_valid;
      if (acc_valid) phys_addr <= next_phys;
    end
  end

  // Code segment joins the return frame only when the extended mode asks for it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      push_code_segment <= 1'b0;
    end else begin
      push_code_segment <= call_event &&
                           extended_mode_control_two[mmu_pkg::EXT2_CS_ENABLE_BIT];
    end
  end

  // ****************************************************************
  // Stacks
  // ****************************************************************
  // Stack location bits come from the mode register.
  assign sp.sys_push       = sys_push;
  assign sp.sys_pop        = sys_pop;
  assign sp.usr_push       = usr_push;
  assign sp.usr_pop        = usr_pop;
  assign sp.load_sys       = load_sys;
  assign sp.load_usr       = load_usr;
  assign sp.load_value     = load_value;
  assign sp.sys_in_regfile = core_mode_control[mmu_pkg::MODE_SYS_STACK_BIT];
  assign sp.usr_in_regfile = core_mode_control[mmu_pkg::MODE_USR_STACK_BIT];
  assign stack_addr        = sp.stack_addr;
  assign stack_regfile     = sp.stack_regfile;
  assign stack_valid       = sp.stack_valid;

  stack_pointer_unit u_stack (
    .clk (clk),
    .rst (rst),
    .sp  (sp.unit)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence dma_access_seq;
    acc_valid && acc_kind == mmu_pkg::ACC_DMA;
  endsequence

  dma_segment_a: assert property (dma_access_seq and dma_page_select |=>
      phys_addr == {$past(dma_segment_reg), $past(acc_addr)})
    else $error("dma access ignored its segment register");
  dma_fallback_a: assert property (dma_access_seq and !dma_page_select |=>
      phys_addr == {$past(interrupt_segment_reg), $past(acc_addr)})
    else $error("dma access did not fall back to interrupt segment");
  data_page_a: assert property (acc_valid && is_data |=>
      phys_addr == {$past(data_page_reg[acc_addr[15:14]]), $past(acc_addr[13:0])})
    else $error("data page not selected by address bits 15 and 14");
  same_latency_a: assert property (acc_valid |=> phys_valid)
    else $error("translated access took an extra cycle");
  remap_write_a: assert property (reg_we && dpr_remap &&
      reg_addr == mmu_pkg::DPR_BASE_E |=> data_page_reg[0] == $past(reg_wdata))
    else $error("relocated data page register not written");
  code_push_a: assert property (call_event |=> push_code_segment ==
      $past(extended_mode_control_two[mmu_pkg::EXT2_CS_ENABLE_BIT]))
    else $error("code segment push does not follow enable bit");
  reset_zero_a: assert property ($fell(rst) |-> code_segment_reg == mmu_pkg::SEG_RESET &&
      data_page_reg[0] == mmu_pkg::REG_RESET)
    else $error("segment or page register not cleared by reset");

  // Program and interrupt fetches extend with their own segment register.
  prog_segment_a: assert property (acc_valid && acc_kind == mmu_pkg::ACC_PROG |=>
      phys_addr == {$past(code_segment_reg), $past(acc_addr)})
    else $error("program fetch ignored the code segment register");
  irq_segment_a: assert property (acc_valid && acc_kind == mmu_pkg::ACC_IRQ |=>
      phys_addr == {$past(interrupt_segment_reg), $past(acc_addr)})
    else $error("interrupt fetch ignored the interrupt segment register");
  page_write_a: assert property (reg_we && !dpr_remap && in_mmu_page &&
      reg_addr == mmu_pkg::DPR_BASE_F |=> data_page_reg[0] == $past(reg_wdata))
    else $error("data page register not written in the memory-management page");
  seg_read_a: assert property (reg_re && hit_dma |=>
      reg_rdata == {2'h0, $past(dma_segment_reg)})
    else $error("segment register read back wrongly");
  usr_place_a: assert property (usr_push && !sys_push && !sys_pop |=>
      stack_regfile == $past(core_mode_control[mmu_pkg::MODE_USR_STACK_BIT]))
    else $error("user stack location not honoured");
endmodule

// File: bench/core_model.sv
// Behavioural core and DMA engine that issue register, address and stack requests.
`timescale 1ns/100ps
module core_model (
  input  wire logic                clk,
  input  wire logic [7:0]          reg_rdata,
  input  wire logic [21:0]         phys_addr,
  input  wire logic                phys_valid,
  input  wire logic                push_code_segment,
  input  wire logic [15:0]         stack_addr,
  input  wire logic                stack_regfile,
  input  wire logic                stack_valid,
  output logic [7:0]               reg_addr,
  output logic [5:0]               page_ptr,
  output logic [7:0]               reg_wdata,
  output logic                     reg_we,
  output logic                     reg_re,
  output logic                     acc_valid,
  output mmu_pkg::acc_kind_t       acc_kind,
  output logic [15:0]              acc_addr,
  output logic                     dma_page_select,
  output logic                     call_event,
  output logic                     sys_push,
  output logic                     sys_pop,
  output logic                     usr_push,
  output logic                     usr_pop,
  output logic                     load_sys,
  output logic                     load_usr,
  output logic [15:0]              load_value
);
  // ****************************************************************
  // Request tasks, all launched and closed on falling edges
  // ****************************************************************
  // Idle values at time zero; the peripheral page starts on the MMU page.
  initial begin
    {reg_addr, reg_wdata, reg_we, reg_re, acc_valid, acc_addr} = '0;
    {dma_page_select, call_event, load_value} = '0;
    {sys_push, sys_pop, usr_push, usr_pop, load_sys, load_usr} = '0;
    page_ptr = 6'h15;
    acc_kind = mmu_pkg::ACC_DATA;
  end
  // Released data lines show the inverse so stale values never match.
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_we    = 1'b1;
    @(negedge clk);
    reg_we    = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_re   = 1'b1;
    @(negedge clk);
    reg_re = 1'b0;
    d      = reg_rdata;
  endtask
  task automatic acc_set(input logic v, input mmu_pkg::acc_kind_t k, input logic [15:0] a,
                         input logic p);
    acc_valid       = v;
    acc_kind        = k;
    acc_addr        = a;
    dma_page_select = p;
  endtask
  task automatic access(input mmu_pkg::acc_kind_t k, input logic [15:0] a, input logic p,
                        output logic [21:0] pa, output logic pv);
    @(negedge clk);
    acc_set(1'b1, k, a, p);
    @(negedge clk);
    pa = phys_addr;
    pv = phys_valid;
    acc_set(1'b0, k, ~a, ~p);
  endtask
  // Operation bits are system push, system pop, user push, user pop, loads.
  task automatic stack_op(input logic [5:0] op, input logic [15:0] v,
                          output logic [15:0] sa, output logic rf, output logic sv);
    @(negedge clk);
    {sys_push, sys_pop, usr_push, usr_pop, load_sys, load_usr} = op;
    load_value = v;
    @(negedge clk);
    {sys_push, sys_pop, usr_push, usr_pop, load_sys, load_usr} = 6'h00;
    load_value = ~v;
    sa = stack_addr;
    rf = stack_regfile;
    sv = stack_valid;
  endtask
  task automatic call_frame(output logic pcs);
    @(negedge clk);
    call_event = 1'b1;
    @(negedge clk);
    call_event = 1'b0;
    pcs        = push_code_segment;
  endtask
endmodule

// File: bench/tb.sv
// Self-checking bench for the segment and page address extender.
`timescale 1ns/100ps
module tb;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [7:0]         reg_addr, reg_wdata, reg_rdata;
  logic [5:0]         page_ptr;
  logic               reg_we, reg_re, acc_valid, dma_page_select, phys_valid;
  logic               call_event, push_code_segment, stack_regfile, stack_valid;
  logic               sys_push, sys_pop, usr_push, usr_pop, load_sys, load_usr;
  mmu_pkg::acc_kind_t acc_kind;
  logic [15:0]        acc_addr, load_value, stack_addr;
  logic [21:0]        phys_addr;
  int                 n_fail = 0;
  int                 num_checks = 0;
  logic [7:0]         pg [4] = '{8'h20, 8'h02, 8'hC5, 8'h3A};

  mmu_address_extender u_dut (.clk, .rst, .reg_addr, .page_ptr, .reg_wdata, .reg_we,
    .reg_re, .reg_rdata, .acc_valid, .acc_kind, .acc_addr, .dma_page_select, .phys_addr,
    .phys_valid, .call_event, .push_code_segment, .sys_push, .sys_pop, .usr_push,
    .usr_pop, .load_sys, .load_usr, .load_value, .stack_addr, .stack_regfile, .stack_valid);
  core_model u_core (.clk, .reg_rdata, .phys_addr, .phys_valid, .push_code_segment,
    .stack_addr, .stack_regfile, .stack_valid, .reg_addr, .page_ptr, .reg_wdata, .reg_we,
    .reg_re, .acc_valid, .acc_kind, .acc_addr, .dma_page_select, .call_event, .sys_push,
    .sys_pop, .usr_push, .usr_pop, .load_sys, .load_usr, .load_value);

  // The clock toggles every half period of 20 ns.
  always #20 clk = ~clk;

  // ****************************************************************
  // Shared comparison and request helpers
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_core.reg_rd(a, d);
    check(d, exp);
  endtask
  task automatic acc_chk(input mmu_pkg::acc_kind_t k, input logic [15:0] a, input logic p,
                         input logic [21:0] exp);
    logic [21:0] pa;
    logic        pv;
    u_core.access(k, a, p, pa, pv);
    check({pv, pa}, {1'b1, exp});
  endtask
  task automatic stk_chk(input logic [5:0] op, input logic [15:0] exp, input logic rf_exp);
    logic [15:0] sa;
    logic        rf;
    logic        sv;
    u_core.stack_op(op, 16'h0000, sa, rf, sv);
    check({sv, rf, sa}, {1'b1, rf_exp, exp});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    check({phys_valid, stack_valid, push_code_segment}, 3'h0);
    for (int i = 0; i < 4; i++) rd_chk(8'hF0 + 8'(i), 8'h00);
    for (int i = 0; i < 3; i++) rd_chk(8'hF8 + 8'(i), 8'h00);
    acc_chk(mmu_pkg::ACC_DATA, 16'hC123, 1'b0, 22'h000123);
  endtask
  task automatic t_pages;
    for (int i = 0; i < 4; i++) u_core.reg_wr(8'hF0 + 8'(i), pg[i]);
    for (int i = 0; i < 4; i++) rd_chk(8'hF0 + 8'(i), pg[i]);
    rd_chk(8'hE0, 8'h00);
    u_core.page_ptr = 6'h00;
    rd_chk(8'hF0, 8'h00);
    u_core.page_ptr = 6'h15;
    u_core.reg_wr(8'hF6, 8'h20);
    u_core.page_ptr = 6'h00;
    for (int i = 0; i < 4; i++) rd_chk(8'hE0 + 8'(i), pg[i]);
    u_core.reg_wr(8'hE0, 8'h5A);
    rd_chk(8'hE0, 8'h5A);
    u_core.reg_wr(8'hE0, pg[0]);
    u_core.page_ptr = 6'h15;
    rd_chk(8'hF0, 8'h00);
  endtask
  // Back-to-back data accesses, one per quadrant, each answered next cycle.
  task automatic t_data;
    for (int i = 0; i <= 4; i++) begin
      @(negedge clk);
      check(phys_valid, (i > 0));
      if (i > 0) check(phys_addr, {pg[i-1], 14'h25A5});
      u_core.acc_set(i < 4, mmu_pkg::ACC_DATA, {2'(i), 14'h25A5}, 1'b0);
    end
    @(negedge clk);
    check(phys_valid, 1'b0);
  endtask
  task automatic t_segs;
    u_core.reg_wr(8'hFA, 8'hFF);
    rd_chk(8'hFA, 8'h3F);
    u_core.reg_wr(8'hFA, 8'h33);
    u_core.reg_wr(8'hF9, 8'h15);
    u_core.reg_wr(8'hF8, 8'h2A);
    acc_chk(mmu_pkg::ACC_DMA, 16'hBEEF, 1'b1, {6'h33, 16'hBEEF});
    acc_chk(mmu_pkg::ACC_DMA, 16'h0F0F, 1'b0, {6'h15, 16'h0F0F});
    acc_chk(mmu_pkg::ACC_PROG, 16'h8001, 1'b0, {6'h2A, 16'h8001});
    acc_chk(mmu_pkg::ACC_IRQ, 16'h7FFE, 1'b1, {6'h15, 16'h7FFE});
  endtask
  task automatic t_call;
    logic pcs;
    u_core.call_frame(pcs);
    check(pcs, 1'b0);
    u_core.reg_wr(8'hF6, 8'hA0);
    u_core.call_frame(pcs);
    check(pcs, 1'b1);
  endtask
  task automatic t_stack;
    logic [15:0] sa;
    logic        rf;
    logic        sv;
    logic        pcs;
    u_core.reg_wr(8'hEB, 8'h02);
    u_core.stack_op(6'h02, 16'd224, sa, rf, sv);
    stk_chk(6'h20, 16'h00DF, 1'b1);
    stk_chk(6'h10, 16'h00DF, 1'b1);
    stk_chk(6'h10, 16'h00E0, 1'b1);
    u_core.stack_op(6'h01, 16'h0100, sa, rf, sv);
    stk_chk(6'h08, 16'h00FF, 1'b0);
    u_core.call_frame(pcs);
    stk_chk(6'h20, 16'h00E0, 1'b1);
    stk_chk(6'h04, 16'h00FF, 1'b0);
    u_core.reg_wr(8'hEB, 8'h01);
    stk_chk(6'h04, 16'h0100, 1'b1);
    stk_chk(6'h28, 16'h00DF, 1'b0);
    stk_chk(6'h04, 16'h0101, 1'b1);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Reset for two cycles, then run every scenario in turn.
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_pages();
    t_data();
    t_segs();
    t_call();
    t_stack();
    tally_and_finish();
  end
  // The whole run needs well under 200 cycles, so 100 us means a hang.
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
endmodule
